// ### logic/slsu_pkg.sv
package slsu_pkg;

  // ==========================================================
  // Operation select
  typedef enum logic [1:0] {
    arith_shift_left_op,
    arith_shift_right_op,
    logic_shift_left_op,
    no_shift_op
  } slsu_op_e;

  // ==========================================================
  // Destination addressing forms
  typedef enum logic [3:0] {
    mode_reg,
    mode_reg_ind,
    mode_disp8,
    mode_disp16,
    mode_predec,
    mode_postinc,
    mode_abs8,
    mode_abs16,
    mode_imm8,
    mode_imm16
  } slsu_mode_e;

  // ==========================================================
  // Widths and bit positions
  localparam int unsigned SLSU_DATA_W   = 16;
  localparam int unsigned SLSU_BYTE_MSB = 7;
  localparam int unsigned SLSU_WORD_MSB = 15;
  localparam int unsigned SLSU_REG_W    = 3;

  // ==========================================================
  // Values after reset
  localparam logic [15:0] SLSU_RESULT_RST = 16'h0000;
  localparam logic [15:0] SLSU_ADDR_RST   = 16'h0000;
  localparam logic [2:0]  SLSU_REGNUM_RST = 3'h0;
  localparam logic        SLSU_FLAG_RST   = 1'h0;

  // ==========================================================
  // Cycles from accept to write-back
  localparam int unsigned SLSU_LATENCY = 1;

endpackage

// ### logic/slsu_shift_core.sv
`timescale 1ns/1ps

module slsu_shift_core
  import slsu_pkg::*;
(
  input  wire slsu_pkg::slsu_op_e op_in,
  input  wire logic               word_in,
  input  wire logic [15:0]        operand_in,
  output logic      [15:0]        result_out,
  output logic                    neg_out,
  output logic                    zero_out,
  output logic                    ovf_out,
  output logic                    carry_out
);

  // ==========================================================
  // Combinational single-bit shifter
  logic top_bit;
  logic next_bit;

  always_comb begin
    top_bit  = word_in ? operand_in[SLSU_WORD_MSB] : operand_in[SLSU_BYTE_MSB];
    next_bit = word_in ? operand_in[SLSU_WORD_MSB - 1]
                       : operand_in[SLSU_BYTE_MSB - 1];
    result_out = operand_in;
    carry_out  = 1'h0;
    ovf_out    = 1'h0;
    case (op_in)
      arith_shift_left_op, logic_shift_left_op: begin
        if (word_in) begin
          result_out = {operand_in[14:0], 1'h0}; // RULE2
        end else begin
          result_out = {operand_in[15:8], operand_in[6:0], 1'h0}; // RULE10
        end
        carry_out = top_bit; // RULE2
        if (op_in == arith_shift_left_op) begin
          ovf_out = top_bit ^ next_bit; // RULE9
        end else begin
          ovf_out = 1'h0; // RULE8
        end
      end
      arith_shift_right_op: begin
        if (word_in) begin
          result_out = {operand_in[15], operand_in[15:1]}; // RULE3
        end else begin
          result_out = {operand_in[15:8], operand_in[7], operand_in[7:1]};
        end
        carry_out = operand_in[0]; // RULE4
        ovf_out   = 1'h0; // RULE7
      end
      default: begin
        result_out = operand_in;
      end
    endcase
    neg_out  = word_in ? result_out[SLSU_WORD_MSB]
                       : result_out[SLSU_BYTE_MSB]; // RULE5
    zero_out = word_in ? (result_out == 16'h0000)
                       : (result_out[7:0] == 8'h00); // RULE6
  end

endmodule

// ### logic/slsu_shift_unit.sv
`timescale 1ns/1ps

// Function
// RULE1 - The shifted value goes back to the register or memory it came from.
// RULE2 - Shift left moves bits up, carry takes the old top bit, zero enters.
// RULE3 - Shift right moves bits down and keeps the top bit unchanged.
// RULE4 - Shift right loads carry with the bit leaving the lowest place.
// RULE5 - Negative follows the top bit of the result for right and logical.
// RULE6 - Zero is set when every bit of the sized result is zero.
// RULE7 - Shift right always clears overflow.
// RULE8 - Logical left matches arithmetic left except overflow is cleared.
// RULE9 - Arithmetic left sets overflow when the top bit changes.
// RULE10 - Byte uses bit 7 as its top bit and word uses bit 15.
// RULE11 - Register and memory forms are accepted, immediates are refused.
module slsu_shift_unit
  import slsu_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 start_in,
  input  wire slsu_pkg::slsu_op_e   op_in,
  input  wire logic                 word_in,
  input  wire slsu_pkg::slsu_mode_e mode_in,
  input  wire logic [2:0]           reg_num_in,
  input  wire logic [15:0]          ea_in,
  input  wire logic [15:0]          operand_in,
  output logic                      busy_out,
  output logic                      done_out,
  output logic                      illegal_out,
  output logic      [15:0]          result_out,
  output logic                      word_out,
  output logic                      reg_we_out,
  output logic      [2:0]           reg_num_out,
  output logic                      mem_we_out,
  output logic      [15:0]          mem_addr_out,
  output logic                      neg_out,
  output logic                      zero_out,
  output logic                      ovf_out,
  output logic                      carry_out
);

  import slsu_pkg::*;

  // ==========================================================
  // Shift datapath
  logic [15:0] sh_result;
  logic        sh_neg;
  logic        sh_zero;
  logic        sh_ovf;
  logic        sh_carry;

  slsu_shift_core u_core (
    .op_in      (op_in),
    .word_in    (word_in),
    .operand_in (operand_in),
    .result_out (sh_result),
    .neg_out    (sh_neg),
    .zero_out   (sh_zero),
    .ovf_out    (sh_ovf),
    .carry_out  (sh_carry)
  );

  // ==========================================================
  // Sequencer
  typedef enum logic [1:0] {st_idle, st_write, st_refuse} slsu_state_e;

  slsu_state_e state_q;
  slsu_state_e state_d;
  logic        accept;
  logic        is_imm;
  logic        is_reg;
  logic        is_shift;

  always_comb begin
    is_imm   = (mode_in == mode_imm8) || (mode_in == mode_imm16); // RULE11
    is_reg   = (mode_in == mode_reg);
    is_shift = (op_in != no_shift_op);
    accept   = start_in && (state_q == st_idle) && is_shift;
    state_d  = st_idle;
    case (state_q)
      st_idle: begin
        if (accept && is_imm) begin
          state_d = st_refuse; // RULE11
        end else if (accept) begin
          state_d = st_write;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Write-back and flag registers
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [2:0]  regn_q;
  logic [2:0]  regn_d;
  logic        word_q;
  logic        word_d;
  logic        to_reg_q;
  logic        to_reg_d;
  logic [3:0]  flags_q;
  logic [3:0]  flags_d;

  always_comb begin
    result_d = result_q;
    addr_d   = addr_q;
    regn_d   = regn_q;
    word_d   = word_q;
    to_reg_d = to_reg_q;
    flags_d  = flags_q;
    if (accept && !is_imm) begin
      result_d = sh_result;
      addr_d   = ea_in; // RULE1
      regn_d   = reg_num_in; // RULE1
      word_d   = word_in; // RULE10
      to_reg_d = is_reg; // RULE1
      flags_d  = {sh_neg, sh_zero, sh_ovf, sh_carry}; // RULE5 RULE6
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_q <= SLSU_RESULT_RST;
      addr_q   <= SLSU_ADDR_RST;
      regn_q   <= SLSU_REGNUM_RST;
      word_q   <= SLSU_FLAG_RST;
      to_reg_q <= SLSU_FLAG_RST;
      flags_q  <= {4{SLSU_FLAG_RST}};
    end else begin
      result_q <= result_d;
      addr_q   <= addr_d;
      regn_q   <= regn_d;
      word_q   <= word_d;
      to_reg_q <= to_reg_d;
      flags_q  <= flags_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    busy_out     = (state_q != st_idle);
    done_out     = (state_q == st_write);
    illegal_out  = (state_q == st_refuse);
    result_out   = result_q;
    word_out     = word_q;
    reg_we_out   = (state_q == st_write) && to_reg_q; // RULE1
    mem_we_out   = (state_q == st_write) && !to_reg_q; // RULE1
    reg_num_out  = regn_q;
    mem_addr_out = addr_q;
    neg_out      = flags_q[3];
    zero_out     = flags_q[2];
    ovf_out      = flags_q[1];
    carry_out    = flags_q[0];
  end

  // ==========================================================
  // Assertions
  property p_asl_word;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && word_in && op_in == arith_shift_left_op)
    |=> (result_out == {$past(operand_in[14:0]), 1'h0})
        && (carry_out == $past(operand_in[15]));
  endproperty
  a_asl_word: assert property (p_asl_word) // RULE2
    else $error("left shift word result or carry wrong");

  property p_asr_keep_sign;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && op_in == arith_shift_right_op)
    |=> done_out && (neg_out == (word_out ? $past(operand_in[15])
                                          : $past(operand_in[7])));
  endproperty
  a_asr_keep_sign: assert property (p_asr_keep_sign) // RULE3
    else $error("right shift lost the sign bit");

  property p_asr_carry;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && op_in == arith_shift_right_op)
    |=> (carry_out == $past(operand_in[0])) && !ovf_out;
  endproperty
  a_asr_carry: assert property (p_asr_carry) // RULE4
    else $error("right shift carry or overflow wrong");

  property p_neg_flag;
    @(posedge core_clk_in) disable iff (!nrst_in)
    done_out |-> neg_out == (word_out ? result_out[15] : result_out[7]);
  endproperty
  a_neg_flag: assert property (p_neg_flag) // RULE5
    else $error("negative flag disagrees with result");

  property p_zero_flag;
    @(posedge core_clk_in) disable iff (!nrst_in)
    done_out |-> zero_out == (word_out ? (result_out == 16'h0000)
                                       : (result_out[7:0] == 8'h00));
  endproperty
  a_zero_flag: assert property (p_zero_flag) // RULE6
    else $error("zero flag disagrees with result");

  property p_asr_ovf_clear;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && op_in != arith_shift_left_op)
    |=> !ovf_out;
  endproperty
  a_asr_ovf_clear: assert property (p_asr_ovf_clear) // RULE7
    else $error("overflow not cleared");

  property p_lsl_byte;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && !word_in && op_in == logic_shift_left_op)
    |=> (result_out[7:0] == {$past(operand_in[6:0]), 1'h0})
        && (result_out[15:8] == $past(operand_in[15:8]))
        && (carry_out == $past(operand_in[7]));
  endproperty
  a_lsl_byte: assert property (p_lsl_byte) // RULE8
    else $error("logical left byte result wrong");

  property p_asl_ovf;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_imm && word_in && op_in == arith_shift_left_op)
    |=> ovf_out == ($past(operand_in[15]) ^ $past(operand_in[14]));
  endproperty
  a_asl_ovf: assert property (p_asl_ovf) // RULE9
    else $error("left shift overflow wrong");

  property p_dest_same;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && is_reg) |=> reg_we_out && !mem_we_out
                           && (reg_num_out == $past(reg_num_in));
  endproperty
  a_dest_same: assert property (p_dest_same) // RULE1
    else $error("register destination not written back");

  property p_mem_dest;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && !is_reg && !is_imm) |=> mem_we_out && !reg_we_out
                                       && (mem_addr_out == $past(ea_in));
  endproperty
  a_mem_dest: assert property (p_mem_dest) // RULE1
    else $error("memory destination not written back");

  property p_imm_refused;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (accept && is_imm) |=> illegal_out && !reg_we_out && !mem_we_out
                           ##1 !busy_out;
  endproperty
  a_imm_refused: assert property (p_imm_refused) // RULE11
    else $error("immediate destination not refused");

  c_asl_ovf: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    done_out && ovf_out);
  c_asr_byte: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    accept && !word_in && op_in == arith_shift_right_op);
  c_mem_write: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    mem_we_out ##2 reg_we_out);
  c_refuse: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    illegal_out);

endmodule

// ### verif/single_bit_shift_unit_bench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
  failures++; $display("ERROR %0t got %h want %h", $time, (a), (b)); \
  end end

module single_bit_shift_unit_bench;
  import slsu_pkg::*;
  logic        core_clk, nrst, start, word, busy, done, illegal, word_o;
  logic        reg_we, mem_we, neg, zero, ovf, carry;
  slsu_op_e    op;
  slsu_mode_e  mode;
  logic [2:0]  reg_num, reg_num_o;
  logic [15:0] ea, operand, result, mem_addr;
  logic [19:0] last_e;
  int          failures, compares;
  logic [15:0] corner [6] = '{16'h4000, 16'h0040, 16'h8001, 16'h0080,
                              16'h0000, 16'h00FF};

  // ==========================================================
  // Clock and instances
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  slsu_shift_unit slsu_shift_unit_i (.core_clk_in(core_clk),
    .nrst_in(nrst), .start_in(start), .op_in(op), .word_in(word),
    .mode_in(mode), .reg_num_in(reg_num), .ea_in(ea),
    .operand_in(operand), .busy_out(busy), .done_out(done),
    .illegal_out(illegal), .result_out(result), .word_out(word_o),
    .reg_we_out(reg_we), .reg_num_out(reg_num_o), .mem_we_out(mem_we),
    .mem_addr_out(mem_addr), .neg_out(neg), .zero_out(zero),
    .ovf_out(ovf), .carry_out(carry));

  slsu_operand_model slsu_operand_model_i (.core_clk_in(core_clk),
    .mode_in(mode), .reg_num_in(reg_num), .ea_in(ea),
    .reg_we_in(reg_we), .reg_num_wr_in(reg_num_o), .mem_we_in(mem_we),
    .mem_addr_in(mem_addr), .result_in(result), .operand_out(operand));

  // ==========================================================
  // Expected result and flags n z v c
  function automatic logic [19:0] expect_of(slsu_op_e o, logic w,
                                            logic [15:0] a);
    logic [15:0] r;
    logic        v, c;
    int          m;
    m = w ? 15 : 7;
    if (o == arith_shift_right_op) begin
      r = w ? {a[15], a[15:1]} : {a[15:8], a[7], a[7:1]};
      c = a[0];
      v = 1'b0;
    end else begin
      r = w ? {a[14:0], 1'b0} : {a[15:8], a[6:0], 1'b0};
      c = a[m];
      v = (o == arith_shift_left_op) ? (a[m] ^ a[m - 1]) : 1'b0;
    end
    return {r, r[m], w ? (r == 16'h0000) : (r[7:0] == 8'h00), v, c};
  endfunction

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // One request at a falling edge, checked a cycle later
  task automatic run_op(input slsu_op_e o, input logic w,
                        input slsu_mode_e md, input logic [15:0] v);
    logic [19:0] e;
    logic [2:0]  rn;
    logic [15:0] ad;
    rn = 3'($urandom);
    ad = 16'($urandom);
    if (md == mode_reg) slsu_operand_model_i.regs[rn] = v;
    else slsu_operand_model_i.mem[ad[3:0]] = v;
    e = expect_of(o, w, v);
    op = o;
    word = w;
    mode = md;
    reg_num = rn;
    ea = ad;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    `CHK(busy, 1'b1)
    if (md == mode_imm8 || md == mode_imm16) begin
      `CHK({illegal, done, reg_we, mem_we}, 4'h8)
      `CHK({result, neg, zero, ovf, carry}, last_e)
    end else begin
      `CHK({done, illegal, reg_we, mem_we},
           {2'b10, md == mode_reg, md != mode_reg})
      `CHK(result, e[19:4])
      `CHK({neg, zero}, e[3:2])
      `CHK({ovf, carry}, e[1:0])
      `CHK({word_o, reg_num_o, mem_addr}, {w, rn, ad})
      last_e = e;
    end
    @(negedge core_clk);
    `CHK(busy, 1'b0)
    if (md == mode_imm8 || md == mode_imm16) begin
      `CHK(slsu_operand_model_i.mem[ad[3:0]], v)
    end else if (md == mode_reg) begin
      `CHK(slsu_operand_model_i.regs[rn], e[19:4])
    end else begin
      `CHK(slsu_operand_model_i.mem[ad[3:0]], e[19:4])
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    op = arith_shift_left_op;
    word = 1'b0;
    mode = mode_reg;
    reg_num = 3'h0;
    ea = 16'h0000;
    failures = 0;
    compares = 0;
    last_e = 20'h00000;
    void'($urandom(66));
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    for (int o = 0; o < 3; o++) begin
      for (int k = 0; k < 12; k++) begin
        run_op(slsu_op_e'(o), k[0], slsu_mode_e'(k % 8), corner[k / 2]);
      end
    end
    for (int k = 0; k < 80; k++) begin
      run_op(slsu_op_e'($urandom_range(0, 2)), 1'($urandom),
             slsu_mode_e'($urandom_range(0, 7)), 16'($urandom));
    end
    run_op(arith_shift_left_op, 1'b1, mode_imm8, 16'h1234);
    run_op(logic_shift_left_op, 1'b0, mode_imm16, 16'h8081);
    op = no_shift_op;
    start = 1'b1;
    @(negedge core_clk);
    `CHK({busy, done, reg_we, mem_we}, 4'h0)
    `CHK({result, neg, zero, ovf, carry}, last_e)
    // Start held through the busy cycle is taken once
    op = arith_shift_left_op;
    mode = mode_reg;
    @(negedge core_clk);
    `CHK({busy, done, reg_we, mem_we}, 4'hE)
    @(negedge core_clk);
    start = 1'b0;
    `CHK({busy, done, reg_we, mem_we}, 4'h0)
    @(negedge core_clk);
    run_op(arith_shift_right_op, 1'b1, mode_disp16, 16'hFFFF);
    nrst = 1'b0;
    #1;
    `CHK({done, result, neg, zero, ovf, carry}, 21'h000000)
    @(negedge core_clk);
    nrst = 1'b1;
    last_e = 20'h00000;
    run_op(arith_shift_left_op, 1'b0, mode_reg, 16'h00C0);
    tally_and_finish();
  end
endmodule

// ### verif/slsu_operand_model.sv
`timescale 1ns/1ps

// ==========================================================
// Register file and memory behind the shift unit
module slsu_operand_model
  import slsu_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire slsu_pkg::slsu_mode_e mode_in,
  input  wire logic [2:0]           reg_num_in,
  input  wire logic [15:0]          ea_in,
  input  wire logic                 reg_we_in,
  input  wire logic [2:0]           reg_num_wr_in,
  input  wire logic                 mem_we_in,
  input  wire logic [15:0]          mem_addr_in,
  input  wire logic [15:0]          result_in,
  output logic      [15:0]          operand_out
);
  logic [15:0] regs [8];
  logic [15:0] mem  [16];

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0000;
      regs[i % 8] = 16'h0000;
    end
  end

  // Operand from register or memory form
  assign operand_out = (mode_in == mode_reg) ? regs[reg_num_in]
                                             : mem[ea_in[3:0]];

  // Write-back to the destination
  always @(posedge core_clk_in) begin
    if (reg_we_in) regs[reg_num_wr_in] <= result_in;
    if (mem_we_in) mem[mem_addr_in[3:0]] <= result_in;
  end
endmodule
